// File: src/lft_top.sv
// Purpose: Four logic functions and four timers with a register port
// Assumes: Source signals are synchronous to clk
// Notes:   All times are counts of 100 ms ticks, read back raw
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lft_params.svh"
module lft_top
  import lft_pkg::*;
#(
  parameter int TW = `LFT_TIME_W,
  parameter int TICK_CYCLES = `LFT_TICK_CYC
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Sync reset, active low
  input wire logic [7:0] addr, // Byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after strobe
  input wire logic [3:0] ana_cmp, // Analogue comparators
  input wire logic [3:0] dig_cmp, // Digital comparators
  input wire logic [3:0] ff_in, // Flip-flop outputs
  input wire logic [1:0] ctr_in, // Counter outputs
  output wire logic [3:0] logic_out, // Logic function outputs
  output wire logic [3:0] timer_out // Timer outputs
);
  localparam int NU = `LFT_NUNIT;
  localparam int NS = `LFT_NSRC;
  localparam int DW = $clog2(TICK_CYCLES);

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  logic [DW-1:0] div_reg;
  logic tick_reg;
  wire div_end = (div_reg == DW'(TICK_CYCLES - 1));

  // One tick per 100 ms; slower rates ride on this enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_end ? '0 : div_reg + 1'b1; // R20
      tick_reg <= div_end; // R20
    end
  end

  // ----------------------------------------------------------------
  // Source list
  // ----------------------------------------------------------------
  logic [NS-1:0] src;
  logic [NU-1:0] lout_w;
  logic [NU-1:0] tout_w;

  // Each source in plain and inverted form, pairs in list order
  genvar g;
  generate
    for (g = 0; g < NU; g++) begin : g_src
      assign src[2*g] = ana_cmp[g];
      assign src[2*g+1] = ~ana_cmp[g];
      assign src[8+2*g] = dig_cmp[g];
      assign src[8+2*g+1] = ~dig_cmp[g];
      assign src[16+2*g] = lout_w[g];
      assign src[16+2*g+1] = ~lout_w[g];
      assign src[24+2*g] = tout_w[g];
      assign src[24+2*g+1] = ~tout_w[g];
      assign src[32+2*g] = ff_in[g];
      assign src[32+2*g+1] = ~ff_in[g];
      if (g < 2) begin : g_ctr
        assign src[40+2*g] = ctr_in[g];
        assign src[40+2*g+1] = ~ctr_in[g];
      end
    end
  endgenerate

  // Logic input pick; a function never sees its own output
  function automatic logic lft_pick(input logic [NS-1:0] s, input logic [5:0] sel,
                                    input logic [1:0] own);
    logic self_hit;
    self_hit = (sel[5:1] == (5'h08 + 5'(own)));
    if ((sel < 6'(NS)) && !self_hit) begin
      lft_pick = s[sel];
    end else begin
      lft_pick = 1'b0;
    end
  endfunction : lft_pick

  // Trigger pick; code zero means no source
  function automatic logic lft_trig(input logic [NS-1:0] s, input logic [5:0] sel);
    logic [5:0] idx;
    idx = sel - 6'h01;
    if ((sel != 6'h00) && (sel <= 6'(NS))) begin
      lft_trig = s[idx];
    end else begin
      lft_trig = 1'b0;
    end
  endfunction : lft_trig

  // Operator; the end code passes the left term through unchanged
  function automatic logic lft_op(input logic a, input logic b, input logic [1:0] op);
    case (op)
      LFT_OP_AND: lft_op = a & b;
      LFT_OP_OR: lft_op = a | b;
      LFT_OP_XOR: lft_op = a ^ b;
      default: lft_op = a;
    endcase
  endfunction : lft_op

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [23:0] lin_reg [NU];
  logic [8:0] lop_reg [NU];
  lft_time_t lset_reg [NU];
  lft_time_t lrst_reg [NU];
  logic [5:0] ttrig_reg [NU];
  logic [1:0] tmode_reg [NU];
  lft_time_t tdly_reg [NU];
  lft_time_t ton_reg [NU];
  lft_time_t toff_reg [NU];
  wire [TW-1:0] lval [NU];
  wire [TW-1:0] tval [NU];

  // Misaligned addresses hit nothing, so they neither write nor read
  wire aligned = (addr[1:0] == 2'h0);
  wire is_tm = addr[`LFT_SEL_TIMER];
  wire [1:0] unit = addr[6:5];
  wire [2:0] word = addr[4:2];
  wire wr_lg = wr_en & aligned & ~is_tm;
  wire wr_tm = wr_en & aligned & is_tm;
  // Out of range times saturate at the longest settable time
  wire over = (wdata > 32'(`LFT_TIME_MAX));
  wire [TW-1:0] wtime = over ? TW'(`LFT_TIME_MAX) : wdata[TW-1:0]; // R15

  // ----------------------------------------------------------------
  // Logic functions
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NU; g++) begin : g_lf
      wire sel_me = (unit == 2'(g));
      wire i1 = lft_pick(src, lin_reg[g][5:0], 2'(g));
      wire i2 = lft_pick(src, lin_reg[g][11:6], 2'(g)); // R2
      wire i3 = lft_pick(src, lin_reg[g][17:12], 2'(g)); // R2
      wire i4 = lft_pick(src, lin_reg[g][23:18], 2'(g)); // R2
      wire [1:0] o1 = lop_reg[g][1:0];
      wire [1:0] o2 = lop_reg[g][3:2];
      wire [1:0] o3 = lop_reg[g][5:4];
      wire alt = lop_reg[g][`LFT_ALT_BIT];
      // Once an end code is met, later terms are dropped
      wire stop1 = (o1 == LFT_OP_END); // R1
      wire stop2 = stop1 | (o2 == LFT_OP_END); // R1
      wire stop3 = stop2 | (o3 == LFT_OP_END); // R1
      wire r12 = lft_op(i1, i2, o1); // R1
      wire rd3 = stop2 ? r12 : lft_op(r12, i3, o2);
      wire rdef = stop3 ? rd3 : lft_op(rd3, i4, o3); // R19
      wire r34 = lft_op(i3, i4, o3);
      wire ralt = stop2 ? r12 : lft_op(r12, r34, o2); // R19
      wire raw = alt ? ralt : rdef; // R19
      logic out_reg;
      logic [TW-1:0] cnt_reg;
      wire chg = raw ^ out_reg;
      wire [TW-1:0] lim = raw ? lset_reg[g] : lrst_reg[g];
      wire done = chg & (cnt_reg >= lim);

      // Settings; the same code serves every function
      always_ff @(posedge clk) begin // R6
        if (!reset_n) begin
          lin_reg[g] <= `LFT_LIN_RST; // R2
          lop_reg[g] <= `LFT_LOP_RST; // R1
          lset_reg[g] <= '0;
          lrst_reg[g] <= '0;
        end else if (wr_lg & sel_me) begin
          if (word == `LFT_LW_INPUTS) begin
            lin_reg[g] <= wdata[23:0];
          end
          if (word == `LFT_LW_OPS) begin
            lop_reg[g] <= wdata[8:0];
          end
          if (word == `LFT_LW_SET) begin
            lset_reg[g] <= wtime; // R3
          end
          if (word == `LFT_LW_RST) begin
            lrst_reg[g] <= wtime; // R4
          end
        end
      end

      // Output follows the raw result only after the delay runs out;
      // a bounce back restarts the count from zero
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          out_reg <= 1'b0;
          cnt_reg <= '0;
        end else if (!chg) begin
          cnt_reg <= '0;
        end else if (done) begin // R3 R4 R21
          out_reg <= raw;
          cnt_reg <= '0;
        end else if (tick_reg) begin // R20
          cnt_reg <= cnt_reg + 1'b1;
        end
      end

      assign lout_w[g] = out_reg;
      assign logic_out[g] = out_reg;
      assign lval[g] = cnt_reg; // R5

      a_logic_set_wait: assert property (@(posedge clk) disable iff (!reset_n) // R3
        raw && !out_reg && cnt_reg < lset_reg[g] |=> !out_reg)
        else $error("logic output asserted before set delay");
      a_logic_rst_wait: assert property (@(posedge clk) disable iff (!reset_n) // R4
        !raw && out_reg && cnt_reg < lrst_reg[g] |=> out_reg)
        else $error("logic output released before reset delay");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NU; g++) begin : g_tm
      wire sel_me = (unit == 2'(g));
      lft_tmr_if #(.TW(TW)) tif ();

      // Settings; trigger starts at no source, mode at delay
      always_ff @(posedge clk) begin // R17
        if (!reset_n) begin
          ttrig_reg[g] <= `LFT_TRIG_RST; // R18
          tmode_reg[g] <= `LFT_MODE_RST; // R13
          tdly_reg[g] <= '0;
          ton_reg[g] <= '0;
          toff_reg[g] <= '0;
        end else if (wr_tm & sel_me) begin
          if (word == `LFT_TMW_CFG) begin
            ttrig_reg[g] <= wdata[5:0];
            tmode_reg[g] <= wdata[9:8];
          end
          if (word == `LFT_TMW_DLY) begin
            tdly_reg[g] <= wtime; // R15
          end
          if (word == `LFT_TMW_ON) begin
            ton_reg[g] <= wtime; // R15
          end
          if (word == `LFT_TMW_OFF) begin
            toff_reg[g] <= wtime; // R15
          end
        end
      end

      assign tif.trig = lft_trig(src, ttrig_reg[g]); // R18
      assign tif.mode = tmode_reg[g];
      assign tif.dly = tdly_reg[g];
      assign tif.t_on = ton_reg[g];
      assign tif.t_off = toff_reg[g];

      lft_timer #(.TW(TW)) u_tmr (
        .clk(clk),
        .reset_n(reset_n),
        .tick(tick_reg),
        .bus(tif.unit)
      );

      assign tout_w[g] = tif.out;
      assign timer_out[g] = tif.out;
      assign tval[g] = tif.value; // R16
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Word selection for each half of the map
  wire [31:0] lg_word =
    (word == `LFT_LW_INPUTS) ? 32'(lin_reg[unit]) :
    (word == `LFT_LW_OPS) ? 32'(lop_reg[unit]) :
    (word == `LFT_LW_SET) ? 32'(lset_reg[unit]) :
    (word == `LFT_LW_RST) ? 32'(lrst_reg[unit]) :
    (word == `LFT_LW_VAL) ? 32'(lval[unit]) : 32'h0000_0000; // R5
  wire [31:0] tm_cfg = {22'(0), tmode_reg[unit], 2'h0, ttrig_reg[unit]};
  wire [31:0] tm_word =
    (word == `LFT_TMW_CFG) ? tm_cfg :
    (word == `LFT_TMW_DLY) ? 32'(tdly_reg[unit]) :
    (word == `LFT_TMW_ON) ? 32'(ton_reg[unit]) :
    (word == `LFT_TMW_OFF) ? 32'(toff_reg[unit]) :
    (word == `LFT_TMW_VAL) ? 32'(tval[unit]) : 32'h0000_0000; // R16
  wire [31:0] rd_word = !aligned ? 32'h0000_0000 : (is_tm ? tm_word : lg_word);

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata <= rd_word;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_read_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !rd_en |=> rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!reset_n)
    rd_en && !aligned |=> rdata == 32'h0000_0000)
    else $error("misaligned read returned data");
  a_tick_gap: assert property (@(posedge clk) disable iff (!reset_n) // R20
    tick_reg |=> !tick_reg)
    else $error("tick longer than one cycle");
endmodule : lft_top
`default_nettype wire

// File: src/lft_params.svh
// Purpose: Constants for the logic function and timer block
// Assumes: 200 MHz clock, times held as counts of 100 ms ticks
// Notes:   Offsets are word numbers (address bits 4:2) on the plain register port
//
// Summary of operation
// R1: Operator codes: 0 end, AND, OR, XOR
// R2: Inputs 2-4 pick sources, default inverted cmp2
// R3: Programmable set delay before output asserts
// R4: Programmable reset delay before output deasserts
// R5: Logic delay timer value is readable
// R6: Four identical logic functions
// R7: Timer converts selected trigger by mode
// R8: Delay mode raises output after delay
// R9: Delay mode drops output with trigger
// R10: Alternate mode cycles on then off
// R11: Alternate mode drops output with trigger
// R12: On-time mode prolongs output by on time
// R13: Mode codes off, delay, alternate, on-time
// R14: Timer value untouched by setting changes; a mode change that ends the state clears it
// R15: Times range zero to 9:59:59.9
// R16: Timer running value is readable
// R17: Four identical timers
// R18: Trigger select defaults to none
// R19: Two evaluation orders for four inputs
// R20: Common 100 ms tick for all counting
// R21: Zero time acts immediately
`ifndef LFT_PARAMS_SVH
`define LFT_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LFT_TICK_MS 100
`define LFT_CLK_KHZ 200000
`define LFT_TICK_CYC (`LFT_TICK_MS * `LFT_CLK_KHZ)
`define LFT_TIME_W 19
`define LFT_TIME_MAX 359999
`define LFT_NSRC 44
`define LFT_NUNIT 4

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LFT_SEL_TIMER 7
`define LFT_LW_INPUTS 3'h0
`define LFT_LW_OPS 3'h1
`define LFT_LW_SET 3'h2
`define LFT_LW_RST 3'h3
`define LFT_LW_VAL 3'h4
`define LFT_TMW_CFG 3'h0
`define LFT_TMW_DLY 3'h1
`define LFT_TMW_ON 3'h2
`define LFT_TMW_OFF 3'h3
`define LFT_TMW_VAL 3'h4
`define LFT_ALT_BIT 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LFT_LIN_RST 24'h18_40C0
`define LFT_LOP_RST 9'h015
`define LFT_TRIG_RST 6'h00
`define LFT_MODE_RST 2'h1

`endif

// File: src/lft_pkg.sv
// Purpose: Types shared by the logic function and timer block
// Assumes: Constants come from the params header
// Notes:   Mode and operator codes match the register fields
`include "lft_params.svh"
package lft_pkg;
  typedef logic [`LFT_TIME_W-1:0] lft_time_t;
  typedef enum logic [1:0] {
    LFT_M_OFF = 2'h0,
    LFT_M_DELAY = 2'h1,
    LFT_M_ALT = 2'h2,
    LFT_M_ONT = 2'h3
  } lft_mode_e;
  typedef enum logic [1:0] {
    LFT_OP_END = 2'h0,
    LFT_OP_AND = 2'h1,
    LFT_OP_OR = 2'h2,
    LFT_OP_XOR = 2'h3
  } lft_op_e;
  typedef enum logic [4:0] {
    LFT_ST_IDLE = 5'h01,
    LFT_ST_WAIT = 5'h02,
    LFT_ST_HIGH = 5'h04,
    LFT_ST_LOW = 5'h08,
    LFT_ST_HOLD = 5'h10
  } lft_tst_e;
endpackage : lft_pkg

// File: src/lft_tmr_if.sv
// Purpose: Settings and status of one timer unit
// Assumes: Driven from the register file in the top module
// Notes:   No clocking; carries levels only
`timescale 1ns/1ps
`default_nettype none
interface lft_tmr_if #(parameter int TW = 19);
  logic trig;
  logic [1:0] mode;
  logic [TW-1:0] dly;
  logic [TW-1:0] t_on;
  logic [TW-1:0] t_off;
  logic out;
  logic [TW-1:0] value;
  modport unit (input trig, mode, dly, t_on, t_off, output out, value);
  modport ctl (output trig, mode, dly, t_on, t_off, input out, value);
endinterface : lft_tmr_if
`default_nettype wire

// File: src/lft_timer.sv
// Purpose: One timer: delay, alternate and on-time conversion
// Assumes: tick is a one-cycle pulse every 100 ms
// Notes:   Count is cleared when a mode change sends the timer to idle
`timescale 1ns/1ps
`default_nettype none
`include "lft_params.svh"
module lft_timer
  import lft_pkg::*;
#(
  parameter int TW = `LFT_TIME_W
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Sync reset
  input wire logic tick, // 100 ms enable
  lft_tmr_if.unit bus // Settings and status
);
  lft_tst_e st_reg, st_next;
  logic [TW-1:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  wire m_dly = (bus.mode == LFT_M_DELAY);
  wire m_alt = (bus.mode == LFT_M_ALT);
  wire m_ont = (bus.mode == LFT_M_ONT);
  wire [TW-1:0] cnt_inc = cnt_reg + 1'b1;

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  // Next state; a mode swap that ends the current state drops to idle, which clears the count
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    out_next = 1'b0;
    case (st_reg)
      LFT_ST_IDLE: begin
        cnt_next = '0;
        if (bus.trig & m_dly) begin // R7
          st_next = LFT_ST_WAIT;
        end else if (bus.trig & m_alt) begin // R10
          st_next = LFT_ST_HIGH;
          out_next = 1'b1;
        end else if (bus.trig & m_ont) begin // R12
          st_next = LFT_ST_HOLD;
          out_next = 1'b1;
        end
      end
      LFT_ST_WAIT: begin
        if (!bus.trig | !m_dly) begin // R9
          st_next = LFT_ST_IDLE;
        end else if (cnt_reg >= bus.dly) begin // R8 R21
          st_next = LFT_ST_HIGH;
          out_next = 1'b1;
        end else if (tick) begin // R20
          cnt_next = cnt_inc;
        end
      end
      LFT_ST_HIGH: begin
        if (!bus.trig | !(m_dly | m_alt)) begin // R9 R11
          st_next = LFT_ST_IDLE;
        end else if (m_alt & (cnt_reg >= bus.t_on)) begin // R10
          st_next = LFT_ST_LOW;
          cnt_next = '0;
        end else begin
          out_next = 1'b1;
          if (tick & m_alt) begin
            cnt_next = cnt_inc;
          end
        end
      end
      LFT_ST_LOW: begin
        if (!bus.trig | !m_alt) begin // R11
          st_next = LFT_ST_IDLE;
        end else if (cnt_reg >= bus.t_off) begin // R10
          st_next = LFT_ST_HIGH;
          cnt_next = '0;
          out_next = 1'b1;
        end else if (tick) begin
          cnt_next = cnt_inc;
        end
      end
      LFT_ST_HOLD: begin
        if (!m_ont) begin
          st_next = LFT_ST_IDLE;
        end else if (bus.trig) begin // R12
          cnt_next = '0;
          out_next = 1'b1;
        end else if (cnt_reg >= bus.t_on) begin // R12 R21
          st_next = LFT_ST_IDLE;
        end else begin
          out_next = 1'b1;
          if (tick) begin
            cnt_next = cnt_inc;
          end
        end
      end
      default: begin
        st_next = LFT_ST_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= LFT_ST_IDLE;
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next; // R14
      out_reg <= out_next;
    end
  end

  assign bus.out = out_reg;
  assign bus.value = cnt_reg; // R16

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_dly_zero;
    (m_dly && bus.trig && bus.dly == '0) [*3];
  endsequence
  a_off_low: assert property (bus.mode == LFT_M_OFF |=> !out_reg) // R13
    else $error("timer output high in off mode");
  a_delay_drop: assert property (m_dly && !bus.trig |=> !out_reg) // R9
    else $error("delay output not dropped with trigger");
  a_alt_drop: assert property (m_alt && !bus.trig |=> !out_reg) // R11
    else $error("alternate output not dropped with trigger");
  a_delay_early: assert property (m_dly && !out_reg && cnt_reg < bus.dly |=> !out_reg) // R8
    else $error("delay output rose early");
  a_delay_zero: assert property (s_dly_zero |=> out_reg) // R21
    else $error("zero delay did not act");
  a_ontime_hold: assert property (m_ont && out_reg && cnt_reg < bus.t_on |=> out_reg) // R12
    else $error("on-time output dropped early");
endmodule : lft_timer
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the logic function and timer block
// Assumes: Tick shortened to 4 clocks, so one time count is 4 cycles
// Notes:   Time windows allow for tick phase and two cycles of latency
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lft_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [3:0] ana_cmp = 4'h0;
  logic [3:0] dig_cmp = 4'h0;
  wire logic [3:0] logic_out;
  wire logic [3:0] timer_out;
  logic [31:0] d;
  logic [31:0] v1;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  lft_top #(.TICK_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ana_cmp(ana_cmp),
    .dig_cmp(dig_cmp), .ff_in(4'h0), .ctr_in(2'h0), .logic_out(logic_out),
    .timer_out(timer_out));
  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  // Free-running clock; a hang ends as a failure
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // A gap cycle after each strobe keeps one driver per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic drive(input logic [3:0] a, input logic [3:0] g);
    @(posedge clk);
    ana_cmp <= a;
    dig_cmp <= g;
  endtask : drive
  // Counts cycles until an output bit reaches v, then checks the window
  task automatic await(input string nm, input logic tmr, input int b, input logic v,
                       input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while ((tmr ? timer_out[b] : logic_out[b]) !== v && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk(nm, 32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask : await
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(8'h00, d); chk("logic0 inputs", d, 32'h0018_40C0);
    rd(8'h60, d); chk("logic3 inputs", d, 32'h0018_40C0);
    rd(8'h04, d); chk("logic0 ops", d, 32'h0000_0015);
    rd(8'h08, d); chk("set delay", d, 32'h0000_0000);
    rd(8'h0C, d); chk("reset delay", d, 32'h0000_0000);
    rd(8'h80, d); chk("timer0 cfg", d, 32'h0000_0100);
    rd(8'hE0, d); chk("timer3 cfg", d, 32'h0000_0100);
    rd(8'hAC, d); chk("off time", d, 32'h0000_0000);
    wr(8'h90, 32'h0000_00FF);
    rd(8'h90, d); chk("value read only", d, 32'h0000_0000);
    rd(8'h14, d); chk("unmapped", d, 32'h0000_0000);
  endtask : t_reset
  task automatic t_ops();
    logic [8:0] ops [6] = '{9'h019, 9'h119, 9'h003, 9'h02A, 9'h03F, 9'h009};
    logic [3:0] ana [6] = '{4'h5, 4'h5, 4'h7, 4'hA, 4'hC, 4'h5};
    logic exp [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    drive(4'hD, 4'h0);
    repeat (4) @(posedge clk);
    #1 chk("all logic defaults", 32'(logic_out), 32'h0000_000F);
    for (int i = 0; i < 6; i++) begin
      wr(8'h04, 32'(ops[i]));
      drive(ana[i], 4'h0);
      repeat (4) @(posedge clk);
      #1 chk("logic0 operators", 32'(logic_out[0]), 32'(exp[i]));
    end
    wr(8'h04, 32'h0000_0015);
  endtask : t_ops
  task automatic t_ldelay();
    drive(4'hF, 4'h0);
    wr(8'h08, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0005);
    drive(4'hD, 4'h0);
    await("set delay", 1'b0, 0, 1'b1, 8, 20);
    drive(4'hF, 4'h0);
    await("reset delay", 1'b0, 0, 1'b0, 16, 30);
    drive(4'hD, 4'h0);
    repeat (8) @(posedge clk);
    rd(8'h10, d); chk("logic value", 32'(d >= 1 && d <= 3), 32'h0000_0001);
  endtask : t_ldelay
  task automatic t_tdelay();
    drive(4'h0, 4'h0);
    wr(8'h84, 32'h0000_0003);
    wr(8'h80, 32'h0000_0101);
    drive(4'h1, 4'h0);
    await("delay rise", 1'b1, 0, 1'b1, 8, 20);
    drive(4'h0, 4'h0);
    await("delay fall", 1'b1, 0, 1'b0, 1, 3);
    wr(8'h84, 32'h0000_0000);
    drive(4'h1, 4'h0);
    await("zero delay", 1'b1, 0, 1'b1, 1, 3);
    drive(4'h0, 4'h0);
    wr(8'h84, 32'h0007_FFFF);
    rd(8'h84, d); chk("delay saturates", d, 32'h0005_7E3F);
    drive(4'h1, 4'h0);
    repeat (20) @(posedge clk);
    rd(8'h90, v1); chk("value runs", 32'(v1 != 0), 32'h0000_0001);
    wr(8'h84, 32'h0000_1000);
    repeat (8) @(posedge clk);
    rd(8'h90, d); chk("value kept", 32'(d > v1), 32'h0000_0001);
    drive(4'h0, 4'h0);
  endtask : t_tdelay
  task automatic t_alt_ont();
    wr(8'hA8, 32'h0000_0002);
    wr(8'hAC, 32'h0000_0003);
    wr(8'hA0, 32'h0000_0209);
    dig_cmp <= 4'h1;
    await("alt first high", 1'b1, 1, 1'b1, 1, 4);
    await("alt on time", 1'b1, 1, 1'b0, 4, 10);
    await("alt off time", 1'b1, 1, 1'b1, 8, 14);
    drive(4'h0, 4'h0);
    await("alt stop", 1'b1, 1, 1'b0, 1, 3);
    wr(8'hC8, 32'h0000_0003);
    wr(8'hC0, 32'h0000_0303);
    wr(8'hE0, 32'h0000_0003);
    drive(4'h2, 4'h0);
    await("on-time rise", 1'b1, 2, 1'b1, 1, 4);
    repeat (4) @(posedge clk);
    #1 chk("off mode", 32'(timer_out[3]), 32'h0000_0000);
    drive(4'h0, 4'h0);
    await("on-time hold", 1'b1, 2, 1'b0, 8, 20);
  endtask : t_alt_ont
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_ops();
    t_ldelay();
    t_tdelay();
    t_alt_ont();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
